// *** hw/sohm_map.svh ***
// Purpose: Constants for the supply and oscillator health monitor
// Assumes: 100 MHz fast-oscillator clock
// Notes:   Times are kept in their own units; cycle counts derive from them
//
// Functional notes
// - Balance-switch alerts are masked according to the two highest-cell selections.
// - Differing highest-cell selections mask no balance-switch alert at all.
// - High-voltage regulator off when main supply invalid or die above shutdown limit.
// - After thermal shutdown, regulator stays off until die below lower threshold.
// - Interface-supply undervoltage comparator sets its flag in fault summary one.
// - Interface-supply undervoltage flag held off until power-on reset flag first cleared.
// - Core-supply undervoltage sets the power-on reset flag in top status.
// - Pumping stops at regulation and resumes only after the hysteresis droop.
// - Charge pump disabled whenever the device is in shutdown.
// - Pumping paused during measurement cycles, calibration included, except during settling delays longer than 30 us.
// - Between scan sequences pump runs on fast clock for 57 us.
// - During calibration the intercharge interval is 21 us.
// - Pump keeps running during settling delays longer than 30 us.
// - Outside acquisition the pump is clocked from the slow clock.
// - Pump undervoltage flag set by comparator, blocked until first reset-flag clear.
// - Pump overvoltage disables the pump and sets its flag.
// - Headroom flag reports low headroom, updated during measurements.
// - Pump-disable control set to 1 stops the pump in acquisition.
// - Fast-clock counter sampled every two slow periods; out of tolerance sets fault.
// - Two redundant slow-oscillator fault flags at summary bits 15 and 14.
// - Fast-oscillator error shows as Manchester, parity and third oscillator flags.
// - Supply-multiplexer fault continuously checked and flagged.
// - Power-on reset flag is never masked.
`ifndef SOHM_MAP_SVH
`define SOHM_MAP_SVH
`define SOHM_CLK_HZ        100000000
`define SOHM_US_HZ         1000000
`define SOHM_INTER_US      57
`define SOHM_CAL_US        21
`define SOHM_SETTLE_MAX_US 30
`define SOHM_PUMP_FAST_HZ  83000
`define SOHM_PUMP_SLOW_HZ  32000
`define SOHM_SLOW_MIN_HZ   31129
`define SOHM_SLOW_MAX_HZ   34406
`define SOHM_SLOW_PERIODS  2
`define SOHM_FS_OSC_A      15
`define SOHM_FS_OSC_B      14
`define SOHM_FS_PUMP_OV    13
`define SOHM_FS_PUMP_UV    12
`define SOHM_FS_HDRM       11
`define SOHM_FS_IFACE_UV   10
`define SOHM_FS_MUX        9
`define SOHM_FS_BALSW      8
`define SOHM_TS_POR        14
`define SOHM_TS_FAULT_SUMMARY_ONE      1
`define SOHM_LE_MAN        0
`define SOHM_LE_PAR        1
`define SOHM_LE_OSC3       2
`endif

// *** hw/sohm_pkg.sv ***
// Purpose: Types for the supply and oscillator health monitor
// Assumes: Constants live in sohm_map.svh
// Notes:   State of each module is one packed struct
package sohm_pkg;
  typedef enum logic [1:0] {
    SOHM_PH_IDLE  = 2'b00,
    SOHM_PH_MEAS  = 2'b01,
    SOHM_PH_INTER = 2'b10
  } sohm_phase_e;

  typedef struct packed {
    sohm_phase_e  phase;
    logic [13:0]  inter_cnt;
    logic [11:0]  div_cnt;
    logic         tsd;
    logic         reg_hold;
    logic         hv_en;
    logic         pump_en;
    logic         pump_fast;
    logic         pump_tick;
    logic         por;
    logic         por_cleared;
    logic [15:0]  fault;
    logic [2:0]   link_err;
    logic [13:0]  balsw;
  } sohm_top_s;
endpackage

// *** hw/sohm_osc_if.sv ***
// Purpose: Carries the slow-oscillator check between top and counter
// Assumes: All signals on clk
// Notes:   slow_osc_s is already synchronised
`timescale 1ns/1ps
`default_nettype none
interface sohm_osc_if;
  logic        slow_osc_s;
  logic        fault_pulse;
  logic [13:0] last_count;
  modport mon (input slow_osc_s, output fault_pulse, output last_count);
  modport ctl (output slow_osc_s, input fault_pulse, input last_count);
endinterface
`default_nettype wire

// *** hw/sohm_sync.sv ***
// Purpose: Two-stage synchroniser for asynchronous comparator levels
// Assumes: Inputs may change at any time
// Notes:   Stage one feeds only stage two
`timescale 1ns/1ps
`default_nettype none
module sohm_sync #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sohm_sync_s;

  sohm_sync_s sync_reg;
  sohm_sync_s sync_next;

  // Shift one stage per clock
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = async_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg.s2;
endmodule
`default_nettype wire

// *** hw/sohm_osc_check.sv ***
// Purpose: Measures the slow oscillator against the fast clock
// Assumes: Slow oscillator arrives synchronised
// Notes:   A stopped slow oscillator also reports a fault
`timescale 1ns/1ps
`default_nettype none
module sohm_osc_check #(
  parameter int CNT_W   = 14,
  parameter int MIN_CYC = 5812,
  parameter int MAX_CYC = 6424
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Check results
  sohm_osc_if.mon  osc
);
  typedef struct packed {
    logic             prev;
    logic             half;
    logic [CNT_W-1:0] cnt;
    logic             fault;
    logic [CNT_W-1:0] last;
    logic             armed;
  } sohm_osc_s;

  sohm_osc_s osc_reg;
  sohm_osc_s osc_next;
  logic      rise;

  // Sample the count on every second rising edge
  always_comb begin
    osc_next       = osc_reg;
    osc_next.fault = 1'b0;
    osc_next.prev  = osc.slow_osc_s;
    rise           = osc.slow_osc_s & ~osc_reg.prev;
    osc_next.cnt   = osc_reg.cnt + 1'b1;
    if (rise && !osc_reg.armed) begin
      // Reset lands mid-period, so the first window opens on an edge
      osc_next.armed = 1'b1;
      osc_next.cnt   = '0;
    end else if (rise && osc_reg.half) begin
      osc_next.last  = osc_reg.cnt;
      osc_next.fault = (osc_reg.cnt < CNT_W'(MIN_CYC)) |
                       (osc_reg.cnt > CNT_W'(MAX_CYC));
      osc_next.cnt   = '0;
      osc_next.half  = 1'b0;
    end else if (rise) begin
      osc_next.half = 1'b1;
    end else if (osc_reg.cnt > CNT_W'(MAX_CYC)) begin
      // Missing edges would otherwise never be judged
      osc_next.fault = 1'b1;
      osc_next.cnt   = '0;
      osc_next.half  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_reg <= '0;
    end else begin
      osc_reg <= osc_next;
    end
  end

  assign osc.fault_pulse = osc_reg.fault;
  assign osc.last_count  = 14'(osc_reg.last);
endmodule
`default_nettype wire

// *** hw/sohm_top.sv ***
// Purpose: Supply, charge-pump and oscillator supervision
// Assumes: Comparator inputs are asynchronous levels, host strobes synchronous
// Notes:   Flags are sticky; a clear strobe loses against a same-cycle set
`timescale 1ns/1ps
`default_nettype none
`include "sohm_map.svh"
module sohm_top #(
  parameter int INTER_CYC   = `SOHM_INTER_US * (`SOHM_CLK_HZ / `SOHM_US_HZ),
  parameter int OSC_MIN_CYC = `SOHM_SLOW_PERIODS * `SOHM_CLK_HZ / `SOHM_SLOW_MAX_HZ,
  parameter int OSC_MAX_CYC = `SOHM_SLOW_PERIODS * `SOHM_CLK_HZ / `SOHM_SLOW_MIN_HZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Analog comparators, asynchronous
  input  wire logic        main_supply_ok,
  input  wire logic        therm_above_shdn,
  input  wire logic        therm_below_hyst,
  input  wire logic        iface_supply_uv,
  input  wire logic        core_supply_uv,
  input  wire logic        pump_in_reg,
  input  wire logic        pump_droop,
  input  wire logic        pump_uv,
  input  wire logic        pump_ov,
  input  wire logic        pump_headroom_low,
  input  wire logic        supply_mux_fault,
  input  wire logic        slow_osc,
  // Scan engine status
  input  wire logic        meas_active,
  input  wire logic        scan_done,
  input  wire logic        cal_active,
  input  wire logic [2:0]  settle_active,
  input  wire logic [9:0]  aux_settle_delay,
  input  wire logic [9:0]  cell_settle_delay,
  input  wire logic [9:0]  switch_settle_delay,
  // Host configuration
  input  wire logic        shutdown,
  input  wire logic        pump_disable,
  input  wire logic [3:0]  highest_cell_sel_a,
  input  wire logic [3:0]  highest_cell_sel_b,
  input  wire logic [13:0] balance_switch_raw,
  // Serial-link error events
  input  wire logic        manchester_evt,
  input  wire logic        parity_evt,
  input  wire logic        fast_osc_evt,
  // Host clear strobes, write one to clear
  input  wire logic [15:0] fault_clear,
  input  wire logic        por_clear,
  input  wire logic [2:0]  link_err_clear,
  // Regulator and pump control
  output logic             hv_reg_enable,
  output logic             pump_enable,
  output logic             pump_fast_sel,
  output logic             pump_clk_en,
  // Flags and status
  output logic [13:0]      balance_switch_alert,
  output logic [15:0]      fault_summary_one,
  output logic [15:0]      top_status_reg,
  output logic             power_on_reset_flag,
  output logic             fault_summary_one_alert,
  output logic             manchester_err_flag,
  output logic             parity_err_flag,
  output logic             fast_osc_fault,
  output logic [13:0]      slow_osc_count
);
  // Derived cycle counts
  localparam int CAL_CYC    = `SOHM_CAL_US * (`SOHM_CLK_HZ / `SOHM_US_HZ);
  localparam int FAST_DIV   = `SOHM_CLK_HZ / `SOHM_PUMP_FAST_HZ;
  localparam int SLOW_DIV   = `SOHM_CLK_HZ / `SOHM_PUMP_SLOW_HZ;
  localparam int SYNC_W     = 12;

  // Synchroniser bit positions
  localparam int SY_MAIN    = 0;
  localparam int SY_HOT     = 1;
  localparam int SY_COOL    = 2;
  localparam int SY_IFUV    = 3;
  localparam int SY_COREUV  = 4;
  localparam int SY_INREG   = 5;
  localparam int SY_DROOP   = 6;
  localparam int SY_PUV     = 7;
  localparam int SY_POV     = 8;
  localparam int SY_HDRM    = 9;
  localparam int SY_MUX     = 10;
  localparam int SY_SLOW    = 11;

  sohm_pkg::sohm_top_s top_reg;
  sohm_pkg::sohm_top_s top_next;

  logic [SYNC_W-1:0] cmp_s;
  logic [15:0]       fs_set;
  logic [13:0]       balsw_keep;
  logic              long_settle;
  logic              fast_clk;
  logic              run_phase;
  logic              div_wrap;
  logic [11:0]       div_limit;
  logic [15:0]       status;

  sohm_osc_if osc_bus ();

  // Highest-cell masking: when both selections are equal, bits at or above the selected cell are hidden
  function automatic logic [13:0] balsw_mask(input logic [3:0] sel_a,
                                             input logic [3:0] sel_b);
    logic [13:0] m;
    m = '1;
    if (sel_a == sel_b) begin
      for (int i = 0; i < 14; i++) begin
        m[i] = (4'(i) < sel_a);
      end
    end
    return m;
  endfunction

  // Comparators are asynchronous to the fast clock
  sohm_sync #(
    .WIDTH    (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({slow_osc, supply_mux_fault, pump_headroom_low, pump_ov,
                pump_uv, pump_droop, pump_in_reg, core_supply_uv,
                iface_supply_uv, therm_below_hyst, therm_above_shdn,
                main_supply_ok}),
    .sync_out (cmp_s)
  );

  assign osc_bus.slow_osc_s = cmp_s[SY_SLOW];

  // Slow-oscillator frequency check on the fast clock
  sohm_osc_check #(
    .CNT_W   (14),
    .MIN_CYC (OSC_MIN_CYC),
    .MAX_CYC (OSC_MAX_CYC)
  ) u_osc (
    .clk     (clk),
    .reset_n (reset_n),
    .osc     (osc_bus)
  );

  // Settling delays over the worst case keep the pump alive
  always_comb begin
    long_settle = 1'b0;
    if (settle_active[0] && aux_settle_delay > 10'(`SOHM_SETTLE_MAX_US)) begin
      long_settle = 1'b1;
    end
    if (settle_active[1] && cell_settle_delay > 10'(`SOHM_SETTLE_MAX_US)) begin
      long_settle = 1'b1;
    end
    if (settle_active[2] && switch_settle_delay > 10'(`SOHM_SETTLE_MAX_US)) begin
      long_settle = 1'b1;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    top_next = top_reg;

    // Thermal shutdown latch with hysteresis
    if (cmp_s[SY_HOT]) begin
      top_next.tsd = 1'b1;
    end else if (cmp_s[SY_COOL]) begin
      top_next.tsd = 1'b0;
    end
    top_next.hv_en = cmp_s[SY_MAIN] & ~top_next.tsd;

    // Regulation hold: stop at target, resume after the droop
    if (cmp_s[SY_INREG]) begin
      top_next.reg_hold = 1'b1;
    end else if (cmp_s[SY_DROOP]) begin
      top_next.reg_hold = 1'b0;
    end

    // Acquisition phase tracking
    unique case (top_reg.phase)
      sohm_pkg::SOHM_PH_IDLE: begin
        if (meas_active) begin
          top_next.phase = sohm_pkg::SOHM_PH_MEAS;
        end
      end
      sohm_pkg::SOHM_PH_MEAS: begin
        if (scan_done) begin
          top_next.phase     = sohm_pkg::SOHM_PH_INTER;
          top_next.inter_cnt = cal_active ? 14'(CAL_CYC)
                                          : 14'(INTER_CYC);
        end
      end
      sohm_pkg::SOHM_PH_INTER: begin
        if (meas_active) begin
          top_next.phase = sohm_pkg::SOHM_PH_MEAS;
        end else if (top_reg.inter_cnt <= 14'd1) begin
          top_next.phase = sohm_pkg::SOHM_PH_IDLE;
        end else begin
          top_next.inter_cnt = top_reg.inter_cnt - 14'd1;
        end
      end
      default: begin
        top_next.phase = sohm_pkg::SOHM_PH_IDLE;
      end
    endcase

    // Pump gating: measurement pauses it unless a long settle is running
    run_phase = (top_reg.phase != sohm_pkg::SOHM_PH_MEAS) || long_settle;
    fast_clk  = (top_reg.phase == sohm_pkg::SOHM_PH_INTER) || long_settle;
    top_next.pump_en = run_phase
                     & ~shutdown
                     & ~pump_disable
                     & ~cmp_s[SY_POV]
                     & ~top_next.reg_hold;
    top_next.pump_fast = fast_clk;

    // Pump clock divider, fast or slow rate
    div_limit = fast_clk ? 12'(FAST_DIV - 1) : 12'(SLOW_DIV - 1);
    div_wrap  = (top_reg.div_cnt >= div_limit);
    top_next.div_cnt   = div_wrap ? 12'h000 : top_reg.div_cnt + 12'h001;
    top_next.pump_tick = div_wrap & top_next.pump_en;

    // Fault summary sources
    fs_set                     = 16'h0000;
    fs_set[`SOHM_FS_OSC_A]     = osc_bus.fault_pulse;
    fs_set[`SOHM_FS_OSC_B]     = osc_bus.fault_pulse;
    fs_set[`SOHM_FS_PUMP_OV]   = cmp_s[SY_POV];
    fs_set[`SOHM_FS_PUMP_UV]   = cmp_s[SY_PUV] & top_reg.por_cleared;
    fs_set[`SOHM_FS_HDRM]      = cmp_s[SY_HDRM] & meas_active;
    fs_set[`SOHM_FS_IFACE_UV]  = cmp_s[SY_IFUV] & top_reg.por_cleared;
    fs_set[`SOHM_FS_MUX]       = cmp_s[SY_MUX];
    balsw_keep                 = balsw_mask(highest_cell_sel_a, highest_cell_sel_b);
    top_next.balsw             = balance_switch_raw & balsw_keep;
    fs_set[`SOHM_FS_BALSW]     = |top_next.balsw;

    // Sticky flags: a set in the clear cycle survives
    top_next.fault = (top_reg.fault & ~fault_clear) | fs_set;

    // Power-on reset flag and its first-clear memory
    top_next.por = (top_reg.por & ~por_clear) | cmp_s[SY_COREUV];
    if (por_clear) begin
      top_next.por_cleared = 1'b1;
    end

    // Link error flags fed by the serial receiver
    top_next.link_err = (top_reg.link_err & ~link_err_clear) |
                        {fast_osc_evt, parity_evt, manchester_evt};
  end

  // One register for all state; power-up raises the reset flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      top_reg     <= '0;
      top_reg.por <= 1'b1;
    end else begin
      top_reg <= top_next;
    end
  end

  // Top status word: reset flag is passed without any mask
  always_comb begin
    status                 = 16'h0000;
    status[`SOHM_TS_POR]   = top_reg.por;
    status[`SOHM_TS_FAULT_SUMMARY_ONE] = |top_reg.fault;
  end

  // Control outputs
  assign hv_reg_enable = top_reg.hv_en;
  assign pump_enable   = top_reg.pump_en;
  assign pump_fast_sel = top_reg.pump_fast;
  assign pump_clk_en   = top_reg.pump_tick;

  // Flag outputs
  assign balance_switch_alert    = top_reg.balsw;
  assign fault_summary_one       = top_reg.fault;
  assign top_status_reg          = status;
  assign power_on_reset_flag     = top_reg.por;
  assign fault_summary_one_alert = status[`SOHM_TS_FAULT_SUMMARY_ONE];
  assign manchester_err_flag     = top_reg.link_err[`SOHM_LE_MAN];
  assign parity_err_flag         = top_reg.link_err[`SOHM_LE_PAR];
  assign fast_osc_fault          = top_reg.link_err[`SOHM_LE_OSC3];
  assign slow_osc_count          = osc_bus.last_count;
endmodule
`default_nettype wire

// *** verification/sohm_analog_model.sv ***
// Purpose: Far-side model of the slow oscillator feeding the monitor
// Assumes: Half period is given in fast-clock cycles of 10 ns
// Notes:   A stopped oscillator stands still, as the real one would
`timescale 1ns/1ps
`default_nettype none
module sohm_analog_model (
  // Bench control
  input  wire logic osc_run,
  input  var  int   half_cyc,
  // Oscillator pin
  output logic      slow_osc
);
  // Odd offset keeps edges off the fast clock edge, like an unrelated source
  initial begin
    slow_osc = 1'b0;
    #3;
    forever begin
      if (osc_run) begin
        #(half_cyc * 10);
        slow_osc = ~slow_osc;
      end else begin
        #10;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/sohm_top_asserts.sv ***
// Purpose: Temporal checks on the monitor's ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Repeat counts of four cover the two-stage synchroniser plus state
`timescale 1ns/1ps
`default_nettype none
module sohm_top_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Watched inputs
  input wire logic        main_supply_ok,
  input wire logic        therm_above_shdn,
  input wire logic        pump_ov,
  input wire logic        shutdown,
  input wire logic        pump_disable,
  input wire logic        meas_active,
  input wire logic        scan_done,
  input wire logic [2:0]  settle_active,
  input wire logic        por_clear,
  input wire logic [15:0] fault_clear,
  input wire logic [3:0]  highest_cell_sel_a,
  input wire logic [3:0]  highest_cell_sel_b,
  input wire logic [13:0] balance_switch_raw,
  // Watched outputs
  input wire logic        hv_reg_enable,
  input wire logic        pump_enable,
  input wire logic        pump_fast_sel,
  input wire logic [13:0] balance_switch_alert,
  input wire logic [15:0] fault_summary_one,
  input wire logic [15:0] top_status_reg,
  input wire logic        power_on_reset_flag,
  input wire logic        fault_summary_one_alert
);
  logic por_seen_reg;
  // Set by the first host clear of the reset flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      por_seen_reg <= 1'b0;
    end else if (por_clear) begin
      por_seen_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_por_status: assert property (top_status_reg[14] == power_on_reset_flag)
    else $error("reset flag missing from status");
  chk_alert_or: assert property (fault_summary_one_alert == (|fault_summary_one)
    && top_status_reg[1] == fault_summary_one_alert) else $error("summary alert not OR");
  chk_osc_pair: assert property (fault_summary_one[15] == fault_summary_one[14])
    else $error("oscillator flags disagree");
  chk_ov_stop: assert property (pump_ov[*4] |-> !pump_enable && fault_summary_one[13])
    else $error("overvoltage did not stop pump");
  chk_shdn_stop: assert property (shutdown[*4] |-> !pump_enable)
    else $error("pump runs in shutdown");
  chk_dis_stop: assert property ($rose(pump_disable) ##1 pump_disable[*3] |-> !pump_enable)
    else $error("pump disable ignored");
  chk_hv_off: assert property ((!main_supply_ok || therm_above_shdn)[*4] |-> !hv_reg_enable)
    else $error("regulator on while unsafe");
  chk_flag_sticky: assert property ($fell(fault_summary_one[13]) |-> $past(fault_clear[13]))
    else $error("flag fell without clear");
  chk_uv_gate: assert property (!por_seen_reg |-> !fault_summary_one[12] && !fault_summary_one[10])
    else $error("undervoltage flag before reset clear");
  chk_meas_pause: assert property ((meas_active && settle_active == 3'b000)[*3] |-> !pump_enable)
    else $error("pump runs in measurement");
  chk_inter_fast: assert property (scan_done && $past(meas_active) |-> ##[1:2] pump_fast_sel)
    else $error("no fast rate after scan");
  chk_bal_open: assert property ((highest_cell_sel_a != highest_cell_sel_b && $stable(balance_switch_raw))[*4]
    |-> balance_switch_alert == balance_switch_raw) else $error("balance alert masked");
  chk_sync_delay: assert property ($rose(pump_ov) && !fault_summary_one[13]
    |=> (!fault_summary_one[13])[*2]) else $error("comparator bypassed synchroniser");
endmodule
bind sohm_top sohm_top_asserts u_chk (.*);
`default_nettype wire

// *** verification/sohm_top_bench.sv ***
// Purpose: Self-checking bench for the supply and oscillator monitor
// Assumes: Inputs change at the falling edge; short counts via parameters
// Notes:   Slow oscillator of 200 cycles gives a 400-cycle nominal count
`timescale 1ns/1ps
`default_nettype none
module sohm_top_bench;
  localparam int INTER = 5700, CAL = 2100;
  logic        clk, reset_n, main_supply_ok, therm_above_shdn, therm_below_hyst, osc_run;
  logic        iface_supply_uv, core_supply_uv, pump_in_reg, pump_droop, pump_uv, pump_ov;
  logic        pump_headroom_low, supply_mux_fault, slow_osc, meas_active, scan_done, cal_active;
  logic        shutdown, pump_disable, manchester_evt, parity_evt, fast_osc_evt, por_clear;
  logic        hv_reg_enable, pump_enable, pump_fast_sel, pump_clk_en, power_on_reset_flag;
  logic        fault_summary_one_alert, manchester_err_flag, parity_err_flag, fast_osc_fault;
  logic [2:0]  settle_active, link_err_clear;
  logic [9:0]  aux_settle_delay, cell_settle_delay, switch_settle_delay;
  logic [3:0]  highest_cell_sel_a, highest_cell_sel_b;
  logic [13:0] balance_switch_raw, balance_switch_alert, slow_osc_count;
  logic [15:0] fault_clear, fault_summary_one, top_status_reg;
  int          half_cyc, error_cnt, cmp_count, n_norm, n_cal;
  sohm_top #(.OSC_MIN_CYC(380), .OSC_MAX_CYC(420)) uut (.*);
  sohm_analog_model osc_model (.*);
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle clear strobes
  task automatic clr(input logic [15:0] f, input logic p, input logic [2:0] l);
    fault_clear = f;
    por_clear = p;
    link_err_clear = l;
    cyc(1);
    fault_clear = 16'h0000;
    por_clear = 1'b0;
    link_err_clear = 3'h0;
  endtask
  // One scan; returns the fast interval length
  task automatic scan(input logic cal, output int n);
    int p = 0;
    meas_active = 1'b1;
    cal_active = cal;
    cyc(5);
    chk("pump_meas", 1'b0, pump_enable);
    meas_active = 1'b0;
    scan_done = 1'b1;
    cyc(1);
    scan_done = 1'b0;
    cyc(1);
    chk("fast_sel", 1'b1, pump_fast_sel);
    chk("pump_inter", 1'b1, pump_enable);
    n = 0;
    while (pump_fast_sel === 1'b1 && n < 6000) begin
      p += pump_clk_en;
      cyc(1);
      n++;
    end
    chk("slow_sel", 1'b0, pump_fast_sel);
    chk("pump_tick", 1'b1, p >= n / 1204 && p <= n / 1204 + 1);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: tests need about 10100 cycles
  initial begin
    #200us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {therm_above_shdn, iface_supply_uv, core_supply_uv, pump_in_reg, pump_droop, pump_uv,
     pump_ov, pump_headroom_low, supply_mux_fault, meas_active, scan_done, cal_active, shutdown,
     pump_disable, manchester_evt, parity_evt, fast_osc_evt, por_clear} = '0;
    {settle_active, link_err_clear, aux_settle_delay, cell_settle_delay} = '0;
    {switch_settle_delay, highest_cell_sel_a, highest_cell_sel_b, balance_switch_raw} = '0;
    {main_supply_ok, therm_below_hyst, osc_run} = 3'h7;
    fault_clear = 16'h0000;
    half_cyc = 100;
    error_cnt = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    chk("status_rst", 16'h4000, top_status_reg);
    chk("fault_rst", 16'h0000, fault_summary_one);
    cyc(5);
    chk("hv_on", 1'b1, hv_reg_enable);
    {therm_above_shdn, therm_below_hyst} = 2'b10;
    cyc(5);
    chk("hv_hot", 1'b0, hv_reg_enable);
    therm_above_shdn = 1'b0;
    cyc(5);
    chk("hv_hyst", 1'b0, hv_reg_enable);
    therm_below_hyst = 1'b1;
    cyc(5);
    chk("hv_cool", 1'b1, hv_reg_enable);
    // UV flags wait for the first reset-flag clear
    {pump_uv, iface_supply_uv} = 2'b11;
    cyc(6);
    chk("uv_gated", 16'h0000, fault_summary_one & 16'h1400);
    clr(16'h0000, 1'b1, 3'h0);
    cyc(5);
    chk("uv_set", 16'h1400, fault_summary_one & 16'h1400);
    {pump_uv, iface_supply_uv} = 2'b00;
    cyc(4);
    clr(16'h1400, 1'b0, 3'h0);
    chk("uv_clr", 16'h0000, fault_summary_one);
    core_supply_uv = 1'b1;
    cyc(5);
    chk("por_set", 16'h4000, top_status_reg & 16'h4000);
    core_supply_uv = 1'b0;
    cyc(4);
    clr(16'h0000, 1'b1, 3'h0);
    chk("por_clr", 1'b0, power_on_reset_flag);
    chk("pump_idle", 2'b10, {pump_enable, pump_fast_sel});
    // A clear loses to a present overvoltage
    pump_ov = 1'b1;
    cyc(5);
    chk("ov_set", 2'b10, {fault_summary_one[13], pump_enable});
    clr(16'h2000, 1'b0, 3'h0);
    chk("ov_hold", 2'b11, {fault_summary_one[13], fault_summary_one_alert});
    pump_ov = 1'b0;
    cyc(4);
    clr(16'h2000, 1'b0, 3'h0);
    chk("ov_clr", 2'b00, {fault_summary_one[13], top_status_reg[1]});
    shutdown = 1'b1;
    cyc(5);
    chk("pump_shdn", 1'b0, pump_enable);
    {shutdown, pump_disable} = 2'b01;
    cyc(5);
    chk("pump_dis", 1'b0, pump_enable);
    pump_disable = 1'b0;
    pump_in_reg = 1'b1;
    cyc(5);
    pump_in_reg = 1'b0;
    cyc(5);
    chk("pump_hold", 1'b0, pump_enable);
    pump_droop = 1'b1;
    cyc(5);
    chk("pump_resume", 1'b1, pump_enable);
    pump_droop = 1'b0;
    // Headroom is only judged while measuring
    pump_headroom_low = 1'b1;
    cyc(5);
    chk("hdrm_idle", 1'b0, fault_summary_one[11]);
    meas_active = 1'b1;
    settle_active = 3'h1;
    aux_settle_delay = 10'h01f;
    cyc(5);
    chk("settle_long", 1'b1, pump_enable);
    aux_settle_delay = 10'h01e;
    cyc(4);
    chk("settle_short", 1'b0, pump_enable);
    settle_active = 3'h0;
    scan(1'b0, n_norm);
    chk("hdrm_meas", 1'b1, fault_summary_one[11]);
    pump_headroom_low = 1'b0;
    chk("inter_len", 1'b1, n_norm >= INTER - 4 && n_norm <= INTER + 1);
    scan(1'b1, n_cal);
    chk("cal_short", 1'b1, n_cal >= CAL - 4 && n_cal <= CAL + 1);
    // Equal selections pass only cells below them
    balance_switch_raw = 14'h3fff;
    for (int s = 0; s <= 14; s += 7) begin
      highest_cell_sel_a = 4'(s);
      highest_cell_sel_b = 4'(s);
      cyc(5);
      chk("bal_mask", 16'((1 << s) - 1), balance_switch_alert);
    end
    highest_cell_sel_b = 4'h5;
    cyc(5);
    chk("bal_open", 16'h3fff, balance_switch_alert);
    chk("bal_sum", 1'b1, fault_summary_one[8]);
    {manchester_evt, parity_evt, fast_osc_evt, supply_mux_fault} = 4'hf;
    cyc(1);
    {manchester_evt, parity_evt, fast_osc_evt} = 3'h0;
    cyc(4);
    chk("link_err", 3'h7, {manchester_err_flag, parity_err_flag, fast_osc_fault});
    chk("mux_flag", 1'b1, fault_summary_one[9]);
    clr(16'h0000, 1'b0, 3'h7);
    chk("link_clr", 3'h0, {manchester_err_flag, parity_err_flag, fast_osc_fault});
    chk("osc_good", 2'b00, fault_summary_one[15:14]);
    chk("osc_cnt", 1'b1, slow_osc_count >= 398 && slow_osc_count <= 401);
    half_cyc = 70;
    cyc(1200);
    chk("osc_fast", 2'b11, fault_summary_one[15:14]);
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    chk("rerst", 16'h4000, top_status_reg);
    osc_run = 1'b0;
    cyc(1000);
    chk("osc_stop", 2'b11, fault_summary_one[15:14]);
    report_and_stop();
  end
endmodule
`default_nettype wire
